// file: core/bibl_defines.svh
// constants of the boot image block loader
`ifndef BIBL_DEFINES_SVH
`define BIBL_DEFINES_SVH

// ----------------------------------------
// clock and serial clock timing
// ----------------------------------------
`define BIBL_CLK_KHZ        250000
`define BIBL_SCL_MAX_KHZ    375
// least half period of the serial clock, rounded up
`define BIBL_HALF_CYC       ((`BIBL_CLK_KHZ + 2 * `BIBL_SCL_MAX_KHZ - 1) / (2 * `BIBL_SCL_MAX_KHZ))

// ----------------------------------------
// serial memory access
// ----------------------------------------
`define BIBL_EEPROM_ADDR    7'h50
`define BIBL_IMAGE_START    16'h0000

// ----------------------------------------
// block layout
// ----------------------------------------
`define BIBL_ID_HI          8'h00
`define BIBL_ID_LO          8'h1f
`define BIBL_TGT_MAX        8'h04
`define BIBL_HDR_BYTES      16'h000c
`define BIBL_TRL_BYTES      16'h0004
`define BIBL_MIN_COUNT      16'h0010
`define BIBL_OFS_CHK_HI     16'h0000
`define BIBL_OFS_CHK_LO     16'h0001
`define BIBL_OFS_ID_HI      16'h0002
`define BIBL_OFS_ID_LO      16'h0003
`define BIBL_OFS_TGT        16'h0004
`define BIBL_OFS_ADR_HI     16'h0006
`define BIBL_OFS_ADR_LO     16'h0007
`define BIBL_OFS_CNT_HI     16'h0008
`define BIBL_OFS_CNT_LO     16'h0009
`define BIBL_SUM_FIRST      16'h0002

// ----------------------------------------
// error codes
// ----------------------------------------
`define BIBL_ERR_NONE       3'h0
`define BIBL_ERR_ID         3'h1
`define BIBL_ERR_TGT        3'h2
`define BIBL_ERR_CHK        3'h3
`define BIBL_ERR_NACK       3'h4
`define BIBL_ERR_LEN        3'h5

// ----------------------------------------
// buffer
// ----------------------------------------
`define BIBL_FIFO_DEPTH     32
`define BIBL_FIFO_WIDTH     27

`endif

// file: core/bibl_pkg.sv
// types of the boot image block loader
package bibl_pkg;

  typedef enum logic [3:0] {
    BIBL_IDLE,
    BIBL_START,
    BIBL_WDEV,
    BIBL_WAH,
    BIBL_WAL,
    BIBL_RSTART,
    BIBL_RDEV,
    BIBL_READ,
    BIBL_STOP,
    BIBL_DONE
  } bibl_state_e;

  typedef struct packed {
    bibl_state_e st;
    logic [1:0]  ph;
    logic [8:0]  tmr;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [15:0] idx;
    logic [15:0] cnt;
    logic [15:0] adr;
    logic [7:0]  tgt;
    logic [15:0] chk_hdr;
    logic [7:0]  trl_hi;
    logic [15:0] sum;
    logic        stop_after;
    logic        scl_o;
    logic        scl_oe;
    logic        sda_o;
    logic        sda_oe;
    logic        wr_valid;
    logic [2:0]  wr_tgt;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        busy;
    logic        done;
    logic        err;
    logic [2:0]  err_code;
  } bibl_ld_s;

endpackage

// file: core/bibl_loader.sv
// boot image block loader: serial memory master, block parser and write buffer
//
// Operation
// - the image is read as bus master from an external serial memory, block after block in order.
// - every block opens with a 16-bit checksum, high byte first, covering the checked bytes.
// - header bytes 2 and 3 must be 0x00 then 0x1f or the block is refused.
// - header byte 4 codes 0x00, 0x01, 0x02 pick program ram, external data ram, dsp program ram.
// - codes 0x03 and 0x04 pick dsp coefficient and data ram; 0x05 to 0x0f are reserved.
// - header bytes 6 and 7 give the start address, high first, for the first payload byte.
// - header bytes 8 and 9 give the block length as 12 plus payload plus 4.
// - a header with zero address and zero length ends the download with no payload.
// - a closing group of two zeros and the checksum, over bytes 2 to N+11, ends every block except the zero address, zero length end header.
// - the serial clock never runs faster than 375 kHz.
`timescale 1ns/1ps
`include "bibl_defines.svh"

module bibl_fifo #(
  parameter int W = 27,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } bibl_fifo_s;

  bibl_fifo_s s_q, s_d;
  logic       full;
  logic       empty;

  assign full      = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
  assign empty     = s_q.wp == s_q.rp;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = s_q.mem[s_q.rp[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (in_valid && !full) begin
      s_d.mem[s_q.wp[AW-1:0]] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      s_d.rp = s_q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.mem <= '0;
      s_q.wp  <= '0;
      s_q.rp  <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module bibl_loader
  import bibl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial clock pin, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  // serial data pin, open drain
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // memory write port
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic [2:0]       mem_wr_target,
  output logic [15:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  // status
  output logic             load_busy,
  output logic             load_done,
  output logic             load_error,
  output logic [2:0]       load_error_code
);
  localparam logic [8:0] HALF = 9'(`BIBL_HALF_CYC - 1);

  bibl_ld_s    s_q, s_d;
  logic        push;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [26:0] fifo_out_data;
  logic [26:0] push_data;
  logic        tick;
  logic [7:0]  tx_byte;
  logic        is_write;
  logic [7:0]  rx;

  // ----------------------------------------
  // write buffer
  // ----------------------------------------
  bibl_fifo #(.W(`BIBL_FIFO_WIDTH), .D(`BIBL_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !s_q.wr_valid || mem_wr_ready;
  assign tick           = s_q.tmr == 9'h000;
  assign rx             = {s_q.sh[6:0], sda_i};
  assign is_write       = s_q.st != BIBL_READ;

  always_comb begin
    case (s_q.st)
      BIBL_WDEV: tx_byte = {`BIBL_EEPROM_ADDR, 1'b0};
      BIBL_WAH:  tx_byte = 8'(`BIBL_IMAGE_START >> 8);
      BIBL_WAL:  tx_byte = 8'(`BIBL_IMAGE_START);
      BIBL_RDEV: tx_byte = {`BIBL_EEPROM_ADDR, 1'b1};
      default:   tx_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // sequencer and parser
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    push      = 1'b0;
    push_data = {s_q.tgt[2:0], 16'(s_q.adr + s_q.idx - `BIBL_HDR_BYTES), rx};
    if (!tick) begin
      s_d.tmr = s_q.tmr - 9'h001;
    end
    // output register drains the buffer
    if (fifo_out_ready) begin
      s_d.wr_valid = fifo_out_valid;
      s_d.wr_tgt   = fifo_out_data[26:24];
      s_d.wr_addr  = fifo_out_data[23:8];
      s_d.wr_data  = fifo_out_data[7:0];
    end
    case (s_q.st)
      BIBL_IDLE: begin
        s_d.busy = 1'b1;
        s_d.st   = BIBL_START;
        s_d.ph   = 2'd0;
        s_d.tmr  = HALF;
      end
      BIBL_START, BIBL_RSTART, BIBL_STOP: begin
        if (tick) begin
          s_d.tmr = HALF;
          s_d.ph  = s_q.ph + 2'd1;
          case (s_q.ph)
            2'd0: begin
              s_d.scl_oe = 1'b1;
              s_d.sda_oe = s_q.st == BIBL_STOP;
            end
            2'd1: s_d.scl_oe = 1'b0;
            2'd2: s_d.sda_oe = s_q.st != BIBL_STOP;
            default: begin
              s_d.ph   = 2'd0;
              s_d.bitn = 4'd0;
              case (s_q.st)
                BIBL_START:  s_d.st = BIBL_WDEV;
                BIBL_RSTART: s_d.st = BIBL_RDEV;
                default: begin
                  s_d.st   = BIBL_DONE;
                  s_d.busy = 1'b0;
                  s_d.done = 1'b1;
                end
              endcase
            end
          endcase
        end
      end
      BIBL_WDEV, BIBL_WAH, BIBL_WAL, BIBL_RDEV, BIBL_READ: begin
        if (tick) begin
          case (s_q.ph)
            2'd0: begin
              // stall the bus while the buffer has no room
              if (is_write || s_q.bitn != 4'd0 || fifo_in_ready) begin
                s_d.tmr    = HALF;
                s_d.ph     = 2'd1;
                s_d.scl_oe = 1'b1;
                if (s_q.bitn == 4'd8) begin
                  s_d.sda_oe = !is_write && !s_q.stop_after;
                end else begin
                  s_d.sda_oe = is_write && !tx_byte[3'(4'd7 - s_q.bitn)];
                end
              end
            end
            2'd1: begin
              s_d.tmr    = HALF;
              s_d.ph     = 2'd2;
              s_d.scl_oe = 1'b0;
            end
            default: begin
              s_d.tmr  = HALF;
              s_d.ph   = 2'd0;
              s_d.bitn = s_q.bitn + 4'd1;
              s_d.sh   = rx;
              if (s_q.bitn == 4'd7 && !is_write) begin
                s_d.idx = s_q.idx + 16'h0001;
                if (s_q.idx >= `BIBL_SUM_FIRST &&
                    (s_q.idx < `BIBL_HDR_BYTES || s_q.idx < s_q.cnt - `BIBL_TRL_BYTES)) begin
                  s_d.sum = s_q.sum + {8'h00, rx};
                end
                case (s_q.idx)
                  `BIBL_OFS_CHK_HI: s_d.chk_hdr[15:8] = rx;
                  `BIBL_OFS_CHK_LO: s_d.chk_hdr[7:0] = rx;
                  `BIBL_OFS_ID_HI, `BIBL_OFS_ID_LO: begin
                    if (rx != (s_q.idx[0] ? `BIBL_ID_LO : `BIBL_ID_HI)) begin
                      s_d.err        = 1'b1;
                      s_d.err_code   = `BIBL_ERR_ID;
                      s_d.stop_after = 1'b1;
                    end
                  end
                  `BIBL_OFS_TGT: begin
                    s_d.tgt = rx;
                    if (rx > `BIBL_TGT_MAX) begin
                      s_d.err        = 1'b1;
                      s_d.err_code   = `BIBL_ERR_TGT;
                      s_d.stop_after = 1'b1;
                    end
                  end
                  `BIBL_OFS_ADR_HI: s_d.adr[15:8] = rx;
                  `BIBL_OFS_ADR_LO: s_d.adr[7:0] = rx;
                  `BIBL_OFS_CNT_HI: s_d.cnt[15:8] = rx;
                  `BIBL_OFS_CNT_LO: begin
                    s_d.cnt[7:0] = rx;
                    if (s_q.adr == 16'h0000 && {s_q.cnt[15:8], rx} == 16'h0000) begin
                      s_d.stop_after = 1'b1;
                    end else if ({s_q.cnt[15:8], rx} < `BIBL_MIN_COUNT) begin
                      s_d.err        = 1'b1;
                      s_d.err_code   = `BIBL_ERR_LEN;
                      s_d.stop_after = 1'b1;
                    end
                  end
                  default: begin
                    if (s_q.idx >= `BIBL_HDR_BYTES) begin
                      if (s_q.idx < s_q.cnt - `BIBL_TRL_BYTES) begin
                        push = 1'b1;
                      end else if (s_q.idx == s_q.cnt - 16'h0002) begin
                        s_d.trl_hi = rx;
                      end else if (s_q.idx == s_q.cnt - 16'h0001) begin
                        s_d.idx = 16'h0000;
                        s_d.sum = 16'h0000;
                        if ({s_q.trl_hi, rx} != s_q.sum || s_q.chk_hdr != s_q.sum) begin
                          s_d.err        = 1'b1;
                          s_d.err_code   = `BIBL_ERR_CHK;
                          s_d.stop_after = 1'b1;
                        end
                      end else if (rx != 8'h00) begin
                        s_d.err        = 1'b1;
                        s_d.err_code   = `BIBL_ERR_CHK;
                        s_d.stop_after = 1'b1;
                      end
                    end
                  end
                endcase
              end
              if (s_q.bitn == 4'd8) begin
                s_d.bitn = 4'd0;
                if (is_write && sda_i) begin
                  s_d.err      = 1'b1;
                  s_d.err_code = `BIBL_ERR_NACK;
                  s_d.st       = BIBL_STOP;
                end else begin
                  case (s_q.st)
                    BIBL_WDEV: s_d.st = BIBL_WAH;
                    BIBL_WAH:  s_d.st = BIBL_WAL;
                    BIBL_WAL:  s_d.st = BIBL_RSTART;
                    BIBL_RDEV: s_d.st = BIBL_READ;
                    default:   s_d.st = s_q.stop_after ? BIBL_STOP : BIBL_READ;
                  endcase
                end
              end
            end
          endcase
        end
      end
      BIBL_DONE: begin
        s_d.busy = 1'b0;
      end
      default: begin
        s_d.st = BIBL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q          <= '0;
      s_q.st       <= BIBL_IDLE;
      s_q.err_code <= `BIBL_ERR_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign scl_o           = s_q.scl_o;
  assign scl_oe          = s_q.scl_oe;
  assign sda_o           = s_q.sda_o;
  assign sda_oe          = s_q.sda_oe;
  assign mem_wr_valid    = s_q.wr_valid;
  assign mem_wr_target   = s_q.wr_tgt;
  assign mem_wr_addr     = s_q.wr_addr;
  assign mem_wr_data     = s_q.wr_data;
  assign load_busy       = s_q.busy;
  assign load_done       = s_q.done;
  assign load_error      = s_q.err;
  assign load_error_code = s_q.err_code;
endmodule

// file: verification/bibl_loader_asserts.sv
// port assertions of the boot image block loader
`timescale 1ns/1ps
`include "bibl_defines.svh"

module bibl_loader_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // serial pins
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // write port
  input wire logic        mem_wr_valid,
  input wire logic        mem_wr_ready,
  input wire logic [2:0]  mem_wr_target,
  input wire logic [15:0] mem_wr_addr,
  input wire logic [7:0]  mem_wr_data,
  // status
  input wire logic        load_busy,
  input wire logic        load_done,
  input wire logic        load_error,
  input wire logic [2:0]  load_error_code
);
  localparam int HALF = `BIBL_HALF_CYC;
  localparam int ERR_LIM = 8 * HALF;
  logic        scl_oe_q;
  logic        seen_q;
  logic [15:0] gap_q;
  logic [15:0] err_age_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    scl_oe_q <= scl_oe;
    seen_q <= reset ? 1'b0 : (seen_q | (scl_oe_q & ~scl_oe));
    if (reset || scl_oe != scl_oe_q) gap_q <= 16'h0000;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
    if (reset || !load_error || load_done) err_age_q <= 16'h0000;
    else err_age_q <= err_age_q + 16'h0001;
  end

  sequence idle_then_busy;
    !load_busy && !scl_oe && !sda_oe && !mem_wr_valid ##1 load_busy;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  low_period_a: assert property ($fell(scl_oe) |-> gap_q >= HALF - 1)
    else $error("serial clock low period too short");
  high_period_a: assert property ($rose(scl_oe) && seen_q |-> gap_q >= HALF - 1)
    else $error("serial clock high period too short");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("serial pin driven high");
  reset_idle_a: assert property ($fell(reset) |-> idle_then_busy)
    else $error("start after reset wrong");
  wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
    && $stable(mem_wr_addr) && $stable(mem_wr_data) && $stable(mem_wr_target))
    else $error("write offer changed before taken");
  wr_target_a: assert property (mem_wr_valid |-> mem_wr_target <= 3'h4)
    else $error("write to reserved target");
  err_code_a: assert property (load_error == (load_error_code != `BIBL_ERR_NONE))
    else $error("error flag and code disagree");
  err_sticky_a: assert property (load_error |=> load_error && $stable(load_error_code))
    else $error("error flag not sticky");
  err_stop_a: assert property (err_age_q <= ERR_LIM)
    else $error("loading not stopped after error");
  done_idle_a: assert property (load_done |-> !load_busy && !scl_oe && !sda_oe)
    else $error("bus not released when done");
endmodule

bind bibl_loader bibl_loader_asserts u_bibl_loader_asserts (
  .clk(clk), .reset(reset), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
  .sda_oe(sda_oe), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
  .mem_wr_target(mem_wr_target), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
  .load_busy(load_busy), .load_done(load_done), .load_error(load_error),
  .load_error_code(load_error_code));

// file: verification/bibl_eeprom_model.sv
// behavioural serial memory holding the boot image
`timescale 1ns/1ps

module bibl_eeprom_model (
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  // data line pull-down
  output logic      sda_oe
);
  logic [7:0]  image [0:15];
  logic [7:0]  rx_q [$];
  logic [15:0] ptr_q;
  logic [7:0]  sh;
  logic        rd_mode;
  int          bitc;
  int          nbyte;
  int          nread;

  initial begin
    sda_oe = 1'b0;
    ptr_q = 16'h0000;
    sh = 8'h00;
    rd_mode = 1'b0;
    bitc = 0;
    nbyte = 0;
    nread = 0;
  end

  // start or repeated start, clock must still be high once the lines settle
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b0) begin
      bitc = 0;
      nbyte = 0;
      rd_mode = 1'b0;
    end
  end

  // data line changes only while clock is low
  always @(negedge scl) begin
    if (bitc == 8) sda_oe <= !rd_mode;
    else if (rd_mode) sda_oe <= !image[ptr_q[3:0]][7 - bitc];
    else sda_oe <= 1'b0;
  end

  // sample on clock high, bytes served in order
  always @(posedge scl) begin
    if (bitc < 8) begin
      sh = {sh[6:0], sda};
      bitc = bitc + 1;
    end else begin
      bitc = 0;
      if (rd_mode) begin
        ptr_q = ptr_q + 16'h0001;
        nread = nread + 1;
        rd_mode = !sda;
      end else begin
        rx_q.push_back(sh);
        if (nbyte == 0) rd_mode = sh[0];
        if (nbyte == 1) ptr_q[15:8] = sh;
        if (nbyte == 2) ptr_q[7:0] = sh;
        nbyte = nbyte + 1;
      end
    end
  end
endmodule

// file: verification/tb_bibl_loader.sv
// testbench of the boot image block loader
`timescale 1ns/1ps
`include "bibl_defines.svh"

module tb_bibl_loader;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        scl_o, scl_oe, sda_o, sda_oe, mdl_sda_oe;
  logic        mem_wr_valid, mem_wr_ready = 1'b0;
  logic [2:0]  mem_wr_target, load_error_code;
  logic [15:0] mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic        load_busy, load_done, load_error;
  wire         scl_line = !scl_oe;
  wire         sda_line = !(sda_oe || mdl_sda_oe);
  int          num_errors = 0;
  int          cmp_count = 0;
  int          wr_seen = 0;

  always #2 clk = ~clk;
  always @(posedge clk) mem_wr_ready <= ~mem_wr_ready;
  always @(posedge clk) if (mem_wr_valid === 1'b1) wr_seen++;

  bibl_loader u_bibl_loader (
    .clk(clk), .reset(reset), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_target(mem_wr_target), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .load_busy(load_busy), .load_done(load_done),
    .load_error(load_error), .load_error_code(load_error_code));

  bibl_eeprom_model u_bibl_eeprom_model (.scl(scl_line), .sda(sda_line), .sda_oe(mdl_sda_oe));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mid_reset();
    repeat (3000) @(posedge clk);
    cmp_count++;
    if (load_busy !== 1'b1) fail("not busy during address phase");
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_count++;
    if ({scl_oe, sda_oe, load_busy, mem_wr_valid} !== 4'h0) fail("outputs active in reset");
    reset <= 1'b0;
    u_bibl_eeprom_model.rx_q.delete();
    @(posedge clk);
    #1;
    cmp_count++;
    if (load_busy !== 1'b1) fail("download did not restart");
  endtask

  task automatic t_reserved_target();
    int          n;
    logic [31:0] sent;
    n = 0;
    while (load_done !== 1'b1 && n < 90000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 90000) begin
      fail("load never finished");
      return;
    end
    cmp_count++;
    if (load_error !== 1'b1 || load_error_code !== `BIBL_ERR_TGT) fail("reserved code taken");
    cmp_count++;
    if (wr_seen != 0) fail("payload written after bad target");
    sent = 32'h00000000;
    if (u_bibl_eeprom_model.rx_q.size() == 4)
      sent = {u_bibl_eeprom_model.rx_q[0], u_bibl_eeprom_model.rx_q[1],
              u_bibl_eeprom_model.rx_q[2], u_bibl_eeprom_model.rx_q[3]};
    cmp_count++;
    if (sent !== 32'ha00000a1) fail("address phase wrong");
    cmp_count++;
    if (u_bibl_eeprom_model.nread != 5) fail("read past the target byte");
    cmp_count++;
    if (scl_line !== 1'b1 || sda_line !== 1'b1) fail("bus not released");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  localparam logic [7:0] IMG [0:15] = '{8'h00, 8'h44, 8'h00, 8'h1f, 8'h05, 8'h00, 8'h00,
    8'h10, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h44};

  initial begin
    for (int i = 0; i < 16; i++) u_bibl_eeprom_model.image[i] = IMG[i];
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_mid_reset();
    t_reserved_target();
    close_out();
  end
endmodule
